// >>> pkg/serial_port_cfg.svh
// Timing and size constants for the converter serial port.
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
// Clock period of the block clock in picoseconds.
`define CLK_PERIOD_PS 5000
// Self-clocked bit clock high time in nanoseconds (least).
`define SCLK_HIGH_NS 50
// Self-clocked bit clock low time in nanoseconds (least).
`define SCLK_LOW_NS 150
// Half periods in block clock cycles, rounded up.
`define SCLK_HIGH_CYC ((`SCLK_HIGH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SCLK_LOW_CYC ((`SCLK_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Default word length in bits.
`define WORD_BITS 24
`endif

// >>> pkg/serial_port_pkg.sv
// Types shared by the converter serial port.
package serial_port_pkg;
  // Frame strobes and register select as seen on the pins.
  typedef struct packed {
    logic receive_frame_strobe_n;
    logic transmit_frame_strobe_n;
    logic register_select;
  } frame_pins_type;
  // Register target of an access.
  typedef enum logic [1:0] {
    TGT_CONTROL = 2'h0,
    TGT_DATA_CAL = 2'h1,
    TGT_NONE = 2'h3
  } target_type;
  // Self-clocking sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW = 2'h1,
    ST_HIGH = 2'h3,
    ST_DONE = 2'h2
  } sclk_state_type;
endpackage : serial_port_pkg

// >>> rtl/serial_port_clocking.sv
// Serial clock direction, activation and register select of the port.
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
// Notes on behaviour
// - Self-clocking: device drives serial clock out.
// - Clock toggles only after a frame strobe falls.
// - Clock released when active strobe returns high.
// - Clock released after full word shifted.
// - External mode: serial clock pin is input.
// - Accept continuous or burst external clocks.
// - Select low targets control register.
// - Select high targets data or calibration.
module serial_port_clocking #(
  parameter int WORD_BITS = `WORD_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clock_mode,
  input wire serial_port_pkg::frame_pins_type frame_pins,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic frame_active,
  output logic word_done,
  output serial_port_pkg::target_type access_target
);
  import serial_port_pkg::*;

  // The half-period counter is 8 bits wide, ample for both half periods.
  localparam int CW = 8;
  localparam logic [CW-1:0] HI_CYC = CW'(`SCLK_HIGH_CYC);
  localparam logic [CW-1:0] LO_CYC = CW'(`SCLK_LOW_CYC);
  localparam logic [5:0] LAST_BIT = 6'(WORD_BITS - 1);

  // Two-stage synchronisers for every pin input.
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  // Previous synchronised external clock, for edge finding.
  logic ext_prev_r;
  // Sequencer state and its half-period counter.
  sclk_state_type state_r;
  logic [CW-1:0] cnt_r;
  // Bits shifted so far in this frame.
  logic [5:0] bit_r;
  // Word end seen inside the current frame.
  logic done_r;
  // Registered outputs.
  logic sclk_r;
  logic oe_r;
  logic rise_r;
  logic fall_r;
  target_type target_r;

  // Synchronised copies of the pins.
  logic mode_s;
  logic rfs_s;
  logic tfs_s;
  logic sel_s;
  logic ext_s;
  logic frame_s;
  logic ext_rise;
  logic ext_fall;

  // Pins pass two flip-flops before any logic reads them.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 5'h1F;
      sync2_r <= 5'h1F;
    end else begin
      sync1_r <= {clock_mode, frame_pins.receive_frame_strobe_n,
                  frame_pins.transmit_frame_strobe_n,
                  frame_pins.register_select, sclk_in};
      sync2_r <= sync1_r;
    end
  end

  assign mode_s = sync2_r[4];
  assign rfs_s = sync2_r[3];
  assign tfs_s = sync2_r[2];
  assign sel_s = sync2_r[1];
  assign ext_s = sync2_r[0];
  // A frame is open while either strobe is low.
  assign frame_s = !rfs_s || !tfs_s;
  // External edges come from the second stage and a delayed copy only.
  assign ext_rise = ext_s && !ext_prev_r;
  assign ext_fall = !ext_s && ext_prev_r;

  // Remember the previous external clock level.
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_prev_r <= 1'b1;
    end else begin
      ext_prev_r <= ext_s;
    end
  end

  // Self-clocking sequencer; idle outside frames and in external mode.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (!mode_s || !frame_s) begin
      // Strobe high or external mode: stop at once.
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Toggling starts only inside an open frame.
          if (!done_r) begin
            state_r <= ST_LOW;
            cnt_r <= LO_CYC - 8'h01;
          end
        end
        ST_LOW: begin
          if (cnt_r == '0) begin
            state_r <= ST_HIGH;
            cnt_r <= HI_CYC - 8'h01;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_HIGH: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (bit_r == LAST_BIT) begin
            // Whole word out: stop even with the strobe still low.
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_LOW;
            cnt_r <= LO_CYC - 8'h01;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter, fed by whichever clock is in charge.
  // Bursts of the external clock simply add up, so gaps are harmless.
  always_ff @(posedge clk) begin
    if (srst || !frame_s) begin
      bit_r <= '0;
      done_r <= 1'b0;
    end else if (mode_s) begin
      if (state_r == ST_HIGH && cnt_r == '0) begin
        if (bit_r == LAST_BIT) begin
          done_r <= 1'b1;
        end else begin
          bit_r <= bit_r + 6'h01;
        end
      end
    end else if (ext_rise && !done_r) begin
      if (bit_r == LAST_BIT) begin
        done_r <= 1'b1;
      end else begin
        bit_r <= bit_r + 6'h01;
      end
    end
  end

  // Pin driver: driven only while self-clocking inside a frame.
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      // External mode never drives the pin.
      oe_r <= mode_s && frame_s && (state_r == ST_LOW ||
              state_r == ST_HIGH);
      sclk_r <= (state_r != ST_LOW);
    end
  end

  // Edge strobes for the shifter, from own clock or the host clock.
  always_ff @(posedge clk) begin
    if (srst) begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (mode_s) begin
      // Both pulses lead the driven pin level by one cycle.
      rise_r <= (state_r == ST_LOW) && (cnt_r == '0) && frame_s;
      // A fall opens every low phase, not only the first of the word.
      fall_r <= frame_s && ((state_r == ST_IDLE && !done_r) ||
                (state_r == ST_HIGH && cnt_r == '0 && bit_r != LAST_BIT));
    end else begin
      rise_r <= ext_rise && frame_s && !done_r;
      fall_r <= ext_fall && frame_s && !done_r;
    end
  end

  // Register target follows the select pin every cycle during a frame.
  always_ff @(posedge clk) begin
    if (srst) begin
      target_r <= TGT_NONE;
    end else if (!frame_s) begin
      target_r <= TGT_NONE;
    end else if (sel_s) begin
      target_r <= TGT_DATA_CAL;
    end else begin
      target_r <= TGT_CONTROL;
    end
  end

  // Outputs come straight from flip-flops; the frame level is a plain OR
  // of two synchronised strobes, so it lags the pins by two cycles.
  assign sclk_out = sclk_r;
  assign sclk_oe = oe_r;
  assign sclk_rise = rise_r;
  assign sclk_fall = fall_r;
  assign frame_active = frame_s;
  assign word_done = done_r;
  assign access_target = target_r;
endmodule : serial_port_clocking

// >>> bench/host_clock_model.sv
// Host bit clock source for external clocking mode.
`timescale 1ns/1ps
module host_clock_model (
  output logic sclk_in
);
  // The host idles its clock high and runs it only inside frames.
  initial sclk_in = 1'b1;
  // Sends k clocks of 48 ns; gaps between calls make bursts.
  task automatic burst(input int k);
    // Offset the edges so that none lands on a block clock edge.
    #1.2;
    repeat (k) begin
      #24 sclk_in = 1'b0;
      #24 sclk_in = 1'b1;
    end
  endtask : burst
endmodule : host_clock_model

// >>> bench/clocking_check_properties.sv
// Checker for clock direction, release and register select.
`timescale 1ns/1ps
module clocking_check
  import serial_port_pkg::*;
#(
  parameter int WORD_BITS = 24
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clock_mode,
  input wire frame_pins_type frame_pins,
  input wire logic sclk_in,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic word_done,
  input wire logic frame_active,
  input wire target_type access_target
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [7:0] rises_r; // Bit clocks seen in the open frame.
  // Counts bits so an overlong word shows up.
  always_ff @(posedge clk) begin
    if (srst || !frame_active) rises_r <= 8'h00;
    else if (sclk_rise) rises_r <= rises_r + 8'h01;
  end
  // Select must settle through the pin synchronisers first.
  sequence s_sel_steady;
    $stable(frame_pins.register_select) [*4];
  endsequence
  a_ext_no_drive: assert property (
    !clock_mode && !$past(clock_mode, 4) |-> !sclk_oe)
    else $error("clock driven in external mode");
  a_oe_start: assert property (
    $rose(sclk_oe) |-> frame_active && !sclk_out)
    else $error("clock driven outside a frame");
  a_strobe_release: assert property (
    $fell(frame_active) |-> ##[0:2] !sclk_oe)
    else $error("clock held after strobe rose");
  a_done_release: assert property (
    word_done && $past(word_done, 2) |-> !sclk_oe)
    else $error("clock held after word");
  a_ext_edge: assert property (
    !clock_mode && frame_active && !word_done && $rose(sclk_in)
    |-> ##[1:5] sclk_rise) else $error("edge lost");
  a_word_limit: assert property (
    rises_r <= WORD_BITS) else $error("too many bits in word");
  a_target_sel: assert property (
    s_sel_steady ##0 frame_active && $past(frame_active, 2)
    |-> access_target == (frame_pins.register_select
    ? TGT_DATA_CAL : TGT_CONTROL)) else $error("wrong target");
  a_target_idle: assert property (
    !frame_active && !$past(frame_active) |-> access_target == TGT_NONE)
    else $error("target without frame");
  // In self clocking the pulses lead the driven pin by one cycle.
  a_fall_leads: assert property (
    sclk_fall && clock_mode |-> ##1 !sclk_out)
    else $error("fall pulse without low clock");
  a_rise_leads: assert property (
    sclk_rise && clock_mode |-> ##1 sclk_out)
    else $error("rise pulse without high clock");
endmodule : clocking_check
bind serial_port_clocking clocking_check #(.WORD_BITS(WORD_BITS)) chk (
  .clk(clk), .srst(srst), .clock_mode(clock_mode), .frame_pins(frame_pins),
  .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
  .sclk_rise(sclk_rise), .sclk_fall(sclk_fall), .word_done(word_done),
  .frame_active(frame_active), .access_target(access_target));

// >>> bench/tb_top.sv
// Self-checking bench for the serial port clocking block.
`timescale 1ns/1ps
module tb_top;
  import serial_port_pkg::*;
  localparam int WB = 24; // Word length handed to the design.
  logic clk, srst, clock_mode, sclk_in, sclk_out, sclk_oe, sclk_rise;
  logic sclk_fall, frame_active, word_done, fa_d = 0, done_seen = 0;
  frame_pins_type frame_pins;
  target_type access_target, tgt_seen = TGT_NONE;
  logic [10:0] exp_q[$]; // Notes of {done, target, bit count}.
  int n_errors = 0, num_checks = 0, cycles = 0, rises = 0;
  logic [31:0] rnd = 32'hF6B4;
  serial_port_clocking #(.WORD_BITS(WB)) serial_port_clocking_inst (
    .clk(clk), .srst(srst), .clock_mode(clock_mode),
    .frame_pins(frame_pins), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .sclk_rise(sclk_rise), .sclk_fall(sclk_fall),
    .frame_active(frame_active), .word_done(word_done),
    .access_target(access_target));
  host_clock_model host_clock_model_inst (.sclk_in(sclk_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t frame gave %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Tallies a frame and compares it with the oldest note when it closes.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      end_sim();
    end else begin
      fa_d <= frame_active;
      if (frame_active) begin
        rises += sclk_rise;
        done_seen <= done_seen | word_done;
        tgt_seen <= access_target;
      end
      if (fa_d && !frame_active && exp_q.size() > 0) begin
        check({done_seen, tgt_seen, rises[7:0]},
              exp_q.pop_front());
        rises = 0;
        done_seen <= 1'b0;
      end
    end
  end
  // Opens a frame, clocks n bits, closes it; an early close cuts the word.
  task automatic frame(logic m, logic tx, logic sel, int n);
    int k, b;
    clock_mode <= m;
    repeat (8) @(posedge clk);
    frame_pins <= {tx, !tx, sel};
    exp_q.push_back({(n >= WB), sel ? TGT_DATA_CAL : TGT_CONTROL,
      8'((n < WB) ? n : WB)});
    repeat (4) @(posedge clk);
    // Self clocking: wait for the device to shift the wanted bits.
    while (m && rises < n && !word_done) @(posedge clk);
    // External clocking: bursts of random length with idle gaps.
    k = 0;
    while (!m && k < n) begin
      rnd = xs(rnd);
      b = 1 + int'(rnd[3:0]);
      host_clock_model_inst.burst((b > n - k) ? n - k : b);
      k += b;
      repeat (4) @(posedge clk);
    end
    repeat (12) @(posedge clk);
    frame_pins <= {2'h3, sel};
  endtask : frame
  initial begin
    srst = 1'b1;
    clock_mode = 1'b1;
    frame_pins = 3'h6;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    frame(1'b1, 1'b0, 1'b0, WB);
    frame(1'b1, 1'b1, 1'b1, 5);
    frame(1'b0, 1'b0, 1'b1, WB);
    frame(1'b0, 1'b1, 1'b0, 30);
    repeat (3) begin
      rnd = xs(rnd);
      frame(rnd[0], rnd[1], rnd[2], 1 + int'(rnd[7:3]) % WB);
    end
    repeat (8) @(posedge clk);
    end_sim();
  end
endmodule : tb_top
